// >>> hw/video_clamp_filter_config.sv
// What this block does
// R1: Fine clamp length sets slow current on-time
// R2: Fast clamp length sets fast current on-time
// R3: Current clamp enable gates all current sources
// R4: Voltage clamp enable gates voltage clamp
// R5: Twelve-bit offset split over two registers
// R6: Offset added to samples in manual mode
// R7: Mode bit: automatic or chroma-only manual
// R8: Freeze holds clamp loop correction
// R9: Timing field picks loop time constant
// R10: Five-bit luma shaping filter selection
// R11: Three-bit chroma shaping filter selection
// R12: Comb mode field, adaptive bit, 11 banned
// R13: 28-bit manual subcarrier frequency stored
// R14: Manual enable chooses user frequency
// R15: Software writes reserved fields as documented
`timescale 1ns/1ps
module video_clamp_filter_config #(
  parameter int SAMPLE_W = 10,
  parameter longint TC_SLOW_CYC = clamp_filter_pkg::TC_SLOW_CYC,
  parameter longint TC_MED_CYC = clamp_filter_pkg::TC_MED_CYC,
  parameter longint TC_FAST_CYC = clamp_filter_pkg::TC_FAST_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [9:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic clamp_start_i,
  input wire logic video_quality_indication_i,
  input wire logic sample_valid_i,
  input wire logic [SAMPLE_W-1:0] sample_i,
  input wire logic [SAMPLE_W-1:0] loop_correction_i,
  output logic [SAMPLE_W-1:0] sample_o,
  output logic slow_current_on_o,
  output logic fast_current_on_o,
  output logic voltage_clamp_on_o,
  output logic clamp_loop_step_o,
  output clamp_filter_pkg::filter_cfg_s cfg_o
);
  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0] analog_clamp_control_q; // Clamp lengths and enables
  logic [7:0] digital_clamp_control_high_q; // Mode, timing, offset hi
  logic [7:0] digital_clamp_offset_low_q; // Offset low byte
  logic [7:0] shaping_filter_control_q; // Luma and chroma filters
  logic [7:0] comb_filter_control_q; // Comb mode and adaptive
  logic [7:0] subcarrier_control_upper_q; // Enable and freq top
  logic [23:0] subcarrier_low_q; // Frequency bits 23:0
  logic [11:0] loop_corr_q; // Held clamp correction

  // Word index taken from a byte address
  function automatic logic [7:0] reg_index(input logic [9:0] a);
    reg_index = a[9:2];
  endfunction

  // Qualified APB phases
  logic wr_access;
  logic rd_setup;
  logic [7:0] idx;
  assign idx = reg_index(paddr_i);
  assign wr_access = psel_i & penable_i & pwrite_i;
  assign rd_setup = psel_i & ~penable_i & ~pwrite_i;

  // ****************************************************************
  // Register writes
  // ****************************************************************
  // Reserved bits are held at their documented constants, so a sloppy
  // write of the reserved fields cannot reach the core
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      analog_clamp_control_q <= clamp_filter_pkg::RST_REG;
      digital_clamp_control_high_q <= clamp_filter_pkg::RST_REG;
      digital_clamp_offset_low_q <= clamp_filter_pkg::RST_REG;
      shaping_filter_control_q <= clamp_filter_pkg::RST_REG;
      comb_filter_control_q <= clamp_filter_pkg::RST_REG;
      subcarrier_control_upper_q <= clamp_filter_pkg::SUBC_RSV_ONES;
      subcarrier_low_q <= 24'h000000;
    end else if (wr_access) begin
      case (idx)
        clamp_filter_pkg::IDX_ANALOG_CLAMP: begin
          analog_clamp_control_q <= pwdata_i[7:0] &
                                    clamp_filter_pkg::ANALOG_MASK; // R15
        end
        clamp_filter_pkg::IDX_DCLAMP_HIGH: begin
          digital_clamp_control_high_q <= pwdata_i[7:0]; // R5
        end
        clamp_filter_pkg::IDX_DCLAMP_LOW: begin
          digital_clamp_offset_low_q <= pwdata_i[7:0]; // R5
        end
        clamp_filter_pkg::IDX_SHAPING: begin
          shaping_filter_control_q <= pwdata_i[7:0]; // R10
        end
        clamp_filter_pkg::IDX_COMB: begin
          // The banned comb code is dropped; old value kept
          if (pwdata_i[3:2] != clamp_filter_pkg::COMB_INVALID) begin
            comb_filter_control_q <= pwdata_i[7:0] &
                                     clamp_filter_pkg::COMB_MASK; // R12
          end
        end
        clamp_filter_pkg::IDX_SUBC_UPPER: begin
          subcarrier_control_upper_q <= (pwdata_i[7:0] &
              clamp_filter_pkg::SUBC_MASK) |
              clamp_filter_pkg::SUBC_RSV_ONES; // R14
        end
        clamp_filter_pkg::IDX_SUBC_MID: begin
          subcarrier_low_q[23:16] <= pwdata_i[7:0]; // R13
        end
        clamp_filter_pkg::IDX_SUBC_LOWMID: begin
          subcarrier_low_q[15:8] <= pwdata_i[7:0]; // R13
        end
        clamp_filter_pkg::IDX_SUBC_LOW: begin
          subcarrier_low_q[7:0] <= pwdata_i[7:0]; // R13
        end
        default: begin
          // Unmapped or read-only: ignored, answered with error
        end
      endcase
    end
  end

  // ****************************************************************
  // APB answer: no wait state, data and error with pready
  // ****************************************************************
  logic mapped;
  always_comb begin
    case (idx)
      clamp_filter_pkg::IDX_ANALOG_CLAMP,
      clamp_filter_pkg::IDX_DCLAMP_HIGH,
      clamp_filter_pkg::IDX_DCLAMP_LOW,
      clamp_filter_pkg::IDX_SHAPING,
      clamp_filter_pkg::IDX_COMB,
      clamp_filter_pkg::IDX_SUBC_UPPER,
      clamp_filter_pkg::IDX_SUBC_MID,
      clamp_filter_pkg::IDX_SUBC_LOWMID,
      clamp_filter_pkg::IDX_SUBC_LOW: mapped = 1'b1;
      clamp_filter_pkg::IDX_CLAMP_STATUS: mapped = ~pwrite_i;
      default: mapped = 1'b0;
    endcase
  end

  // Read data is captured in setup so pready comes from a flop
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h00000000;
    end else if (rd_setup) begin
      case (idx)
        clamp_filter_pkg::IDX_ANALOG_CLAMP:
          prdata_o <= {24'h000000, analog_clamp_control_q};
        clamp_filter_pkg::IDX_DCLAMP_HIGH:
          prdata_o <= {24'h000000, digital_clamp_control_high_q};
        clamp_filter_pkg::IDX_DCLAMP_LOW:
          prdata_o <= {24'h000000, digital_clamp_offset_low_q};
        clamp_filter_pkg::IDX_SHAPING:
          prdata_o <= {24'h000000, shaping_filter_control_q};
        clamp_filter_pkg::IDX_COMB:
          prdata_o <= {24'h000000, comb_filter_control_q};
        clamp_filter_pkg::IDX_SUBC_UPPER:
          prdata_o <= {24'h000000, subcarrier_control_upper_q};
        clamp_filter_pkg::IDX_SUBC_MID:
          prdata_o <= {24'h000000, subcarrier_low_q[23:16]};
        clamp_filter_pkg::IDX_SUBC_LOWMID:
          prdata_o <= {24'h000000, subcarrier_low_q[15:8]};
        clamp_filter_pkg::IDX_SUBC_LOW:
          prdata_o <= {24'h000000, subcarrier_low_q[7:0]};
        clamp_filter_pkg::IDX_CLAMP_STATUS:
          prdata_o <= {18'h00000, slow_current_on_o, fast_current_on_o,
                       loop_corr_q};
        default: prdata_o <= 32'h00000000;
      endcase
    end
  end

  // Pready rises in the first access cycle and drops after it
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~mapped;
    end
  end

  // ****************************************************************
  // Analog clamp current pulses
  // ****************************************************************
  // Length is 16 shifted left by the 2-bit code: 16/32/64/128
  function automatic logic [7:0] clamp_len(input logic [1:0] code);
    clamp_len = 8'(clamp_filter_pkg::CLAMP_BASE_CYC << code);
  endfunction

  logic cur_en;
  assign cur_en = analog_clamp_control_q[clamp_filter_pkg::CUR_EN_BIT];
  logic [7:0] slow_cnt_q;
  logic [7:0] fast_cnt_q;

  // Slow current counter; enable low kills it at once
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !cur_en) begin
      slow_cnt_q <= 8'h00; // R3
    end else if (clamp_start_i) begin
      slow_cnt_q <= clamp_len(analog_clamp_control_q[1:0]); // R1
    end else if (slow_cnt_q != 8'h00) begin
      slow_cnt_q <= slow_cnt_q - 8'h01; // R1
    end
  end

  // Fast current counter, same shape
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !cur_en) begin
      fast_cnt_q <= 8'h00; // R3
    end else if (clamp_start_i) begin
      fast_cnt_q <= clamp_len(analog_clamp_control_q[3:2]); // R2
    end else if (fast_cnt_q != 8'h00) begin
      fast_cnt_q <= fast_cnt_q - 8'h01; // R2
    end
  end

  // Current-on outputs follow the counters one edge late
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      slow_current_on_o <= 1'b0;
      fast_current_on_o <= 1'b0;
      voltage_clamp_on_o <= 1'b0;
    end else begin
      slow_current_on_o <= cur_en & (slow_cnt_q != 8'h00); // R1 R3
      fast_current_on_o <= cur_en & (fast_cnt_q != 8'h00); // R2 R3
      voltage_clamp_on_o <=
        analog_clamp_control_q[clamp_filter_pkg::VOLT_EN_BIT]; // R4
    end
  end

  // ****************************************************************
  // Digital clamp loop timing and freeze
  // ****************************************************************
  logic [31:0] tc_cnt_q;
  logic [31:0] tc_limit;
  logic freeze;
  assign freeze =
    digital_clamp_control_high_q[clamp_filter_pkg::FREEZE_BIT];

  // Good video allows the fast constant, poor video the slow one
  always_comb begin
    case (clamp_filter_pkg::tc_e'(digital_clamp_control_high_q[6:5]))
      clamp_filter_pkg::TC_SLOW: tc_limit = 32'(TC_SLOW_CYC); // R9
      clamp_filter_pkg::TC_MED: tc_limit = 32'(TC_MED_CYC); // R9
      clamp_filter_pkg::TC_FAST: tc_limit = 32'(TC_FAST_CYC); // R9
      default: tc_limit = video_quality_indication_i ?
                          32'(TC_FAST_CYC) : 32'(TC_SLOW_CYC); // R9
    endcase
  end

  // Step pulse marks one loop time-constant period
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      tc_cnt_q <= 32'h00000000;
      clamp_loop_step_o <= 1'b0;
    end else if (freeze) begin
      clamp_loop_step_o <= 1'b0; // R8
    end else if (tc_cnt_q + 32'h00000001 >= tc_limit) begin
      tc_cnt_q <= 32'h00000000;
      clamp_loop_step_o <= 1'b1; // R9
    end else begin
      tc_cnt_q <= tc_cnt_q + 32'h00000001;
      clamp_loop_step_o <= 1'b0;
    end
  end

  // Correction from the loop is latched only on an unfrozen step
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      loop_corr_q <= 12'h000;
    end else if (clamp_loop_step_o && !freeze) begin
      loop_corr_q <= 12'(loop_correction_i); // R8
    end
  end

  // ****************************************************************
  // Sample correction path (chroma samples)
  // ****************************************************************
  logic manual;
  logic [11:0] offset;
  assign manual = digital_clamp_control_high_q[clamp_filter_pkg::MODE_BIT];
  assign offset = {digital_clamp_control_high_q[3:0],
                   digital_clamp_offset_low_q}; // R5

  // Wraps on overflow; core saturation is left to downstream logic
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sample_o <= '0;
    end else if (sample_valid_i) begin
      if (manual) begin
        sample_o <= sample_i + SAMPLE_W'(offset); // R6 R7
      end else begin
        sample_o <= sample_i + SAMPLE_W'(loop_corr_q); // R7
      end
    end
  end

  // ****************************************************************
  // Configuration bundle to the core
  // ****************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cfg_o <= '0;
    end else begin
      cfg_o.current_clamp_enable <= cur_en; // R3
      cfg_o.voltage_clamp_enable <= analog_clamp_control_q[5]; // R4
      cfg_o.clamp_mode_select <= manual; // R7
      cfg_o.clamp_freeze <= freeze; // R8
      cfg_o.clamp_time_constant <= digital_clamp_control_high_q[6:5];
      cfg_o.manual_chroma_offset <= offset; // R5
      cfg_o.luma_shaping_select <= shaping_filter_control_q[4:0]; // R10
      cfg_o.chroma_shaping_select <= shaping_filter_control_q[7:5]; // R11
      cfg_o.comb_mode <= comb_filter_control_q[3:2]; // R12
      cfg_o.comb_adaptive_select <= comb_filter_control_q[4]; // R12
      cfg_o.subcarrier_manual_enable <=
        subcarrier_control_upper_q[clamp_filter_pkg::SUBC_EN_BIT]; // R14
      cfg_o.manual_subcarrier_frequency <=
        {subcarrier_control_upper_q[3:0], subcarrier_low_q}; // R13
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_cur_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !cur_en |=> !slow_current_on_o && !fast_current_on_o) // R3
    else $error("current source on while disabled");
  a_slow_len: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    clamp_start_i && cur_en && analog_clamp_control_q[1:0] == 2'h0
    |=> slow_cnt_q == 8'h10) // R1
    else $error("slow clamp length wrong");
  a_fast_len: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    clamp_start_i && cur_en && analog_clamp_control_q[3:2] == 2'h3
    |=> fast_cnt_q == 8'h80) // R2
    else $error("fast clamp length wrong");
  a_volt_en: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ##1 voltage_clamp_on_o == $past(analog_clamp_control_q[5])) // R4
    else $error("voltage clamp enable mismatch");
  a_offs_add: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    sample_valid_i && manual
    |=> sample_o == $past(sample_i) + SAMPLE_W'($past(offset))) // R6
    else $error("manual offset not applied");
  a_freeze_hold: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) freeze [*2] |=> $stable(loop_corr_q)) // R8
    else $error("loop moved while frozen");
  a_comb_valid: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) comb_filter_control_q[3:2] != 2'h3) // R12
    else $error("invalid comb mode stored");
  a_subc_rsv: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) subcarrier_control_upper_q[7:5] == 3'h7) // R15
    else $error("subcarrier reserved bits lost");
  a_apb_ready: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) psel_i && !penable_i |=> pready_o) // APB no wait state
    else $error("pready late");
  c_slow_pulse: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(slow_current_on_o));
  c_manual: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    sample_valid_i && manual);
  c_step: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    clamp_loop_step_o);
endmodule // video_clamp_filter_config

// >>> pkg/clamp_filter_pkg.sv
package clamp_filter_pkg;
  // ****************************************************************
  // Register offsets (word indices; the bus byte address is the index times four)
  // ****************************************************************
  // Printed offsets are not all multiples of four, so they are indices
  localparam logic [7:0] IDX_ANALOG_CLAMP = 8'h14;
  localparam logic [7:0] IDX_DCLAMP_HIGH = 8'h15;
  localparam logic [7:0] IDX_DCLAMP_LOW = 8'h16;
  localparam logic [7:0] IDX_SHAPING = 8'h17;
  localparam logic [7:0] IDX_COMB = 8'h19;
  localparam logic [7:0] IDX_SUBC_UPPER = 8'h23;
  // Lower frequency bytes and loop status
  localparam logic [7:0] IDX_SUBC_MID = 8'h24;
  localparam logic [7:0] IDX_SUBC_LOWMID = 8'h25;
  localparam logic [7:0] IDX_SUBC_LOW = 8'h26;
  localparam logic [7:0] IDX_CLAMP_STATUS = 8'h30;
  localparam int ADDR_W = 10;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int FINE_LEN_LSB = 0;
  localparam int FAST_LEN_LSB = 2;
  localparam int CUR_EN_BIT = 4;
  localparam int VOLT_EN_BIT = 5;
  localparam int OFFS_HI_LSB = 0;
  localparam int FREEZE_BIT = 4;
  localparam int TC_LSB = 5;
  localparam int MODE_BIT = 7;
  localparam int LUMA_LSB = 0;
  localparam int CHROMA_LSB = 5;
  localparam int COMB_MODE_LSB = 2;
  localparam int COMB_AD_BIT = 4;
  localparam int SUBC_EN_BIT = 4;

  // ****************************************************************
  // Reset values and reserved patterns
  // ****************************************************************
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] SUBC_RSV_ONES = 8'hE0;
  localparam logic [7:0] ANALOG_MASK = 8'h3F;
  localparam logic [7:0] COMB_MASK = 8'h1C;
  localparam logic [7:0] SUBC_MASK = 8'h1F;
  localparam logic [1:0] COMB_INVALID = 2'h3;

  // ****************************************************************
  // Timing: clock and loop time constants
  // ****************************************************************
  localparam longint CLK_HZ = 10_000_000;
  localparam longint TC_SLOW_MS = 1000;
  localparam longint TC_MED_MS = 500;
  localparam longint TC_FAST_MS = 100;
  localparam longint TC_SLOW_CYC = TC_SLOW_MS * CLK_HZ / 1000;
  localparam longint TC_MED_CYC = TC_MED_MS * CLK_HZ / 1000;
  localparam longint TC_FAST_CYC = TC_FAST_MS * CLK_HZ / 1000;
  localparam int CLAMP_BASE_CYC = 16;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {TC_SLOW, TC_MED, TC_FAST, TC_QUAL} tc_e;
  typedef enum logic [1:0] {COMB_NONE, COMB_1LINE, COMB_2LINE,
                            COMB_BAD} comb_e;

  // Configuration bundle delivered to the video core
  typedef struct packed {
    logic current_clamp_enable;
    logic voltage_clamp_enable;
    logic clamp_mode_select;
    logic clamp_freeze;
    logic [1:0] clamp_time_constant;
    logic [11:0] manual_chroma_offset;
    logic [4:0] luma_shaping_select;
    logic [2:0] chroma_shaping_select;
    logic [1:0] comb_mode;
    logic comb_adaptive_select;
    logic subcarrier_manual_enable;
    logic [27:0] manual_subcarrier_frequency;
  } filter_cfg_s;
endpackage

// >>> verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // ****************************************************************
  // Clock, reset and design hookup
  // ****************************************************************
  localparam longint TCS = 40; // Shortened loop periods keep the run brief
  localparam longint TCM = 20;
  localparam longint TCF = 10;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, clamp_start = 1'b0, vid_good = 1'b0;
  logic svalid = 1'b0, slow_on, fast_on, volt_on, loop_step;
  logic [9:0] sample = 10'h000, sample_out;
  logic [9:0] loop_corr = 10'h005; // Correction from outside loop; changed to 9 while frozen
  clamp_filter_pkg::filter_cfg_s cfg;
  int miscompares = 0;
  int cmp_count = 0;
  logic [31:0] rd;
  logic er;

  video_clamp_filter_config #(.TC_SLOW_CYC(TCS), .TC_MED_CYC(TCM),
    .TC_FAST_CYC(TCF)) uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .clamp_start_i(clamp_start),
    .video_quality_indication_i(vid_good), .sample_valid_i(svalid),
    .sample_i(sample), .loop_correction_i(loop_corr),
    .sample_o(sample_out), .slow_current_on_o(slow_on),
    .fast_current_on_o(fast_on), .voltage_clamp_on_o(volt_on),
    .clamp_loop_step_o(loop_step), .cfg_o(cfg));

  // Free-running system clock, 100 ns period
  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; pready, data and error taken at the rising edge
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", 32'h0, 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  // Read back and compare, including the error flag
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk("read", rd, {24'h000000, exp});
    chk("pslverr", {31'h0, er}, 32'h0);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Reset values, unmapped access refused
  task automatic t_reset_values();
    rdchk(clamp_filter_pkg::IDX_ANALOG_CLAMP, 8'h00);
    rdchk(clamp_filter_pkg::IDX_DCLAMP_HIGH, 8'h00);
    rdchk(clamp_filter_pkg::IDX_DCLAMP_LOW, 8'h00);
    rdchk(clamp_filter_pkg::IDX_SHAPING, 8'h00);
    rdchk(clamp_filter_pkg::IDX_COMB, 8'h00);
    rdchk(clamp_filter_pkg::IDX_SUBC_UPPER, 8'hE0);
    apb(1'b0, 8'h20, 8'h00);
    chk("unmapped err", {31'h0, er}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("test reset_values done");
  endtask

  // Pulse lengths per code, enable gating, voltage clamp bit
  task automatic t_clamp();
    int ns, nf;
    for (int c = 0; c < 5; c++) begin
      // Code 4 means both sources switched off
      wr(clamp_filter_pkg::IDX_ANALOG_CLAMP, (c < 4) ?
         8'((3 - c) << 2 | c | 8'h10) : 8'h0F);
      @(posedge clk_sys_i);
      clamp_start <= 1'b1;
      @(posedge clk_sys_i);
      clamp_start <= 1'b0;
      ns = 0;
      nf = 0;
      repeat (200) begin
        @(negedge clk_sys_i);
        ns += int'(slow_on === 1'b1);
        nf += int'(fast_on === 1'b1);
      end
      chk("slow len", ns, (c < 4) ? 16 << c : 0);
      chk("fast len", nf, (c < 4) ? 16 << (3 - c) : 0);
    end
    wr(clamp_filter_pkg::IDX_ANALOG_CLAMP, 8'hE0);
    idle(2);
    chk("volt on", {31'h0, volt_on}, 32'h1);
    chk("volt cfg", cfg.voltage_clamp_enable, 32'h1);
    rdchk(clamp_filter_pkg::IDX_ANALOG_CLAMP, 8'h20);
    wr(clamp_filter_pkg::IDX_ANALOG_CLAMP, 8'h00);
    idle(2);
    chk("volt off", {31'h0, volt_on}, 32'h0);
    chk("cur cfg", cfg.current_clamp_enable, 32'h0);
    $display("test clamp done");
  endtask

  // Split offset, manual mode applied to samples with wrap
  task automatic t_offset();
    wr(clamp_filter_pkg::IDX_DCLAMP_HIGH, 8'h8A);
    wr(clamp_filter_pkg::IDX_DCLAMP_LOW, 8'hBC);
    idle(2);
    chk("offset", cfg.manual_chroma_offset, 32'hABC);
    chk("mode", cfg.clamp_mode_select, 32'h1);
    rdchk(clamp_filter_pkg::IDX_DCLAMP_HIGH, 8'h8A);
    @(posedge clk_sys_i);
    svalid <= 1'b1;
    sample <= 10'h3F0;
    @(posedge clk_sys_i);
    svalid <= 1'b0;
    @(negedge clk_sys_i);
    chk("sample", sample_out, 32'h2AC);
    $display("test offset done");
  endtask

  // Every chroma code and luma range edges
  task automatic t_filters();
    logic [4:0] luma [8] = '{5'h00, 5'h01, 5'h02, 5'h12, 5'h13, 5'h16,
                             5'h18, 5'h1F};
    for (int i = 0; i < 8; i++) begin
      wr(clamp_filter_pkg::IDX_SHAPING, {3'(i), luma[i]});
      idle(2);
      chk("luma", cfg.luma_shaping_select, luma[i]);
      chk("chroma", cfg.chroma_shaping_select, i);
    end
    $display("test filters done");
  endtask

  // Comb modes, reserved bits forced low, banned mode ignored
  task automatic t_comb();
    for (int m = 0; m < 3; m++) begin
      wr(clamp_filter_pkg::IDX_COMB, 8'(8'hF3 | m << 2));
      rdchk(clamp_filter_pkg::IDX_COMB, 8'(8'h10 | m << 2));
      chk("comb cfg", cfg.comb_mode, m);
      chk("adaptive", cfg.comb_adaptive_select, 32'h1);
    end
    wr(clamp_filter_pkg::IDX_COMB, 8'h0C);
    rdchk(clamp_filter_pkg::IDX_COMB, 8'h18);
    $display("test comb done");
  endtask

  // Manual subcarrier frequency across four registers
  task automatic t_subc();
    wr(clamp_filter_pkg::IDX_SUBC_UPPER, 8'h1A);
    wr(clamp_filter_pkg::IDX_SUBC_MID, 8'h56);
    wr(clamp_filter_pkg::IDX_SUBC_LOWMID, 8'h78);
    wr(clamp_filter_pkg::IDX_SUBC_LOW, 8'h9A);
    idle(2);
    rdchk(clamp_filter_pkg::IDX_SUBC_UPPER, 8'hFA);
    chk("freq", cfg.manual_subcarrier_frequency, 32'hA56789A);
    chk("fsc man", cfg.subcarrier_manual_enable, 32'h1);
    $display("test subcarrier done");
  endtask

  // Spacing of loop steps per timing code, then freeze
  task automatic t_loop();
    int t, p;
    longint exp [5] = '{TCS, TCM, TCF, TCF, TCS};
    for (int c = 0; c < 5; c++) begin
      @(posedge clk_sys_i);
      vid_good <= (c == 3);
      wr(clamp_filter_pkg::IDX_DCLAMP_HIGH, 8'((c < 4 ? c : 3) << 5));
      t = 0;
      p = 0;
      // Skip one step so the new period is settled
      repeat (130) begin
        @(negedge clk_sys_i);
        t++;
        if (loop_step === 1'b1) begin
          p = (p == 0) ? -1 : t;
          t = 0;
        end
      end
      chk("step period", p, int'(exp[c]));
      chk("tc cfg", cfg.clamp_time_constant, (c < 4) ? c : 3);
    end
    wr(clamp_filter_pkg::IDX_DCLAMP_HIGH, 8'h10);
    idle(2);
    loop_corr <= 10'h009; // New loop value offered while frozen
    p = 0;
    repeat (100) begin
      @(negedge clk_sys_i);
      p += int'(loop_step === 1'b1);
    end
    chk("frozen steps", p, 0);
    chk("freeze cfg", cfg.clamp_freeze, 32'h1);
    rdchk(clamp_filter_pkg::IDX_CLAMP_STATUS, 8'h05);
    apb(1'b1, clamp_filter_pkg::IDX_CLAMP_STATUS, 8'hFF);
    chk("status wr err", {31'h0, er}, 32'h1);
    // Automatic mode adds the held correction
    @(posedge clk_sys_i);
    svalid <= 1'b1;
    sample <= 10'h100;
    @(posedge clk_sys_i);
    svalid <= 1'b0;
    @(negedge clk_sys_i);
    chk("auto sample", sample_out, 32'h105);
    $display("test loop done");
  endtask

  // ****************************************************************
  // Verdict and main sequence
  // ****************************************************************
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected few thousand cycles
  initial begin
    #(30000 * 100);
    miscompares++;
    end_sim();
  end

  initial begin
    idle(2);
    rst_n_i <= 1'b1;
    t_reset_values();
    t_clamp();
    t_offset();
    t_filters();
    t_comb();
    t_subc();
    t_loop();
    end_sim();
  end
endmodule // tb_top
